// file: src/dad_datapath.sv
// Receive and transmit data path of the DMT line transceiver.
`timescale 1ns/1ps
`default_nettype none
`include "dad_cfg.svh"
module dad_datapath #(
	parameter int NT = 4,
	parameter int DEPTH = `DAD_FIFO_DEPTH,
	parameter logic [23:0] SLIP_THR = `DAD_SLIP_THR
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// APB register port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog front-end nibble link.
	input wire logic [3:0] afe_rx_nib,
	input wire logic afe_word_start,
	output logic [3:0] afe_tx_nib,
	// Time-domain samples to and from the transform engine.
	input wire logic [15:0] tx_smp,
	input wire logic tx_smp_v,
	output logic [15:0] rx_smp,
	output logic rx_smp_v,
	output logic rx_sym,
	output logic tx_sym,
	// Clock tracking.
	input wire logic [15:0] pe,
	input wire logic pe_v,
	output logic slip_ins,
	output logic slip_del,
	output logic [1:0] rot_q,
	// Demapper.
	input wire logic [15:0] dm_re,
	input wire logic [15:0] dm_im,
	input wire logic [1:0] dm_subset,
	input wire logic dm_v_in,
	output logic [13:0] dm_bits,
	output logic dm_v,
	// Mapper.
	input wire logic [13:0] map_bits,
	input wire logic [3:0] map_n,
	input wire logic map_v_in,
	output logic [15:0] map_re,
	output logic [15:0] map_im,
	output logic map_v,
	output logic map_err,
	// Byte flows and decoder events.
	input wire logic [7:0] fi_data,
	input wire logic fi_v,
	input wire logic [7:0] ff_data,
	input wire logic ff_v,
	input wire logic rs_evt,
	input wire logic crc_evt,
	// User ports.
	output logic [7:0] cell_data,
	output logic cell_v,
	input wire logic cell_rdy,
	output logic [7:0] sync_data,
	output logic sync_v,
	output logic [2:0] port_en
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [15:0] ctrl;
		logic [15:0] fine_tune_gain;
		logic [15:0] clip;
		logic [15:0] feq_act;
		logic [15:0] feq_inact;
		logic feq_swap;
		logic [NT-1:0][15:0] teq_c;
		logic [NT-1:0][15:0] teq_x;
		logic [1:0] rx_ncnt;
		logic [11:0] rx_sh;
		logic [17:0] dec_acc;
		logic [2:0] dec_cnt;
		logic ins_p;
		logic del_p;
		logic [15:0] rx_smp;
		logic rx_smp_v;
		logic [9:0] rx_scnt;
		logic rx_sym;
		logic [15:0] tx_s1;
		logic [15:0] tx_s2;
		logic [15:0] tx_hold;
		logic [11:0] tx_sh;
		logic [3:0] tx_nib;
		logic [9:0] tx_scnt;
		logic tx_sym;
		logic [15:0] lp;
		logic [23:0] est;
		logic slip_ins;
		logic slip_del;
		logic [13:0] dm_bits;
		logic dm_v;
		logic [15:0] map_re;
		logic [15:0] map_im;
		logic map_v;
		logic map_err;
		logic [2:0] tcm_st;
		logic [22:0] dsc_i;
		logic [22:0] dsc_f;
		logic [15:0] rs_cnt;
		logic [15:0] crc_cnt;
		logic ovf;
		logic [DEPTH-1:0][7:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [7:0] cell_data;
		logic cell_v;
		logic [7:0] sync_data;
		logic sync_v;
		logic [2:0] port_en;
	} dad_state_s;

	dad_state_s st_reg;
	dad_state_s st_next;

	// Self-synchronising descrambler x^23 + x^18 + 1, LSB first; returns state and byte.
	function automatic logic [30:0] dsc(input logic [22:0] s, input logic [7:0] d);
		logic [22:0] t;
		logic [7:0] o;
		t = s;
		o = '0;
		for (int b = 0; b < 8; b++) begin
			o[b] = d[b] ^ t[17] ^ t[22];
			t = {t[21:0], d[b]};
		end
		return {t, o};
	endfunction

	logic acc_go, wr_go, hit, word_done, smp_v, sym_now, sel_v, usel, push, pop;
	logic [31:0] rd;
	logic [15:0] word, smp, c1, s2n, ftr, fti, cre, cim, lpn;
	logic [17:0] addv, sum;
	logic [2:0] cntn;
	logic [35:0] tacc;
	logic [NT-1:0][15:0] xn;
	logic [31:0] pr, pi, mre, mim;
	logic [13:0] vre, vim, mb;
	logic [3:0] h, k;
	logic [23:0] estn;
	logic [30:0] oi, of;
	logic [7:0] sel_d;

	// All next-state logic; the register file and every pipeline live in one state record.
	always_comb begin
		st_next = st_reg;
		rd = '0;
		hit = 1'b0;
		st_next.pready = 1'b0;
		st_next.rx_smp_v = 1'b0;
		st_next.rx_sym = 1'b0;
		st_next.tx_sym = 1'b0;
		st_next.slip_ins = 1'b0;
		st_next.slip_del = 1'b0;
		st_next.dm_v = 1'b0;
		st_next.map_v = 1'b0;
		st_next.map_err = 1'b0;
		st_next.sync_v = 1'b0;
		sym_now = 1'b0;
		// Read mux; any address outside the map answers with pslverr.
		case (paddr)
			`DAD_A_CTRL: begin
				hit = 1'b1;
				rd = {16'h0000, st_reg.ctrl};
			end
			`DAD_A_STAT: begin
				hit = 1'b1;
				rd = 32'(st_reg.cnt);
				rd[`DAD_B_OVF] = st_reg.ovf;
				rd[`DAD_B_SWPEND] = st_reg.feq_swap;
			end
			`DAD_A_EVT: begin
				hit = 1'b1;
				rd = {st_reg.crc_cnt, st_reg.rs_cnt};
			end
			`DAD_A_FEQ: begin
				hit = 1'b1;
				rd = {st_reg.feq_act, st_reg.feq_inact};
			end
			`DAD_A_FTG: begin
				hit = 1'b1;
				rd = {16'h0000, st_reg.fine_tune_gain};
			end
			`DAD_A_CLIP: begin
				hit = 1'b1;
				rd = {16'h0000, st_reg.clip};
			end
			`DAD_A_SAMPLE_CLOCK_TRACKER: begin
				hit = 1'b1;
				rd = 32'(signed'(st_reg.est));
			end
			default: begin
				for (int i = 0; i < NT; i++) begin
					if (paddr == 8'(`DAD_A_TEQ + 4 * i)) begin
						hit = 1'b1;
						rd = {16'h0000, st_reg.teq_c[i]};
					end
				end
			end
		endcase
		// One wait state: data and error are latched, then the access completes.
		acc_go = psel & penable & ~st_reg.pready;
		wr_go = psel & penable & st_reg.pready & pwrite & hit;
		if (acc_go) begin
			st_next.pready = 1'b1;
			st_next.pslverr = ~hit;
			st_next.prdata = pwrite ? 32'h0000_0000 : rd;
		end
		// Receive nibble assembly, high nibble first after the word start.
		word_done = (st_reg.rx_ncnt == 2'(`DAD_NIBS - 1)) & ~afe_word_start;
		word = {st_reg.rx_sh, afe_rx_nib};
		st_next.rx_sh = {st_reg.rx_sh[7:0], afe_rx_nib};
		st_next.rx_ncnt = afe_word_start ? 2'd1 : st_reg.rx_ncnt + 2'd1;
		// Decimator; a pending slip drops or doubles one input word.
		addv = st_reg.del_p ? 18'h0_0000 : 18'(signed'(word));
		if (st_reg.ins_p) begin
			addv = addv + addv;
		end
		sum = st_reg.dec_acc + addv;
		cntn = st_reg.dec_cnt + (st_reg.del_p ? 3'd0 : st_reg.ins_p ? 3'd2 : 3'd1);
		smp_v = 1'b0;
		smp = word;
		if (word_done) begin
			st_next.ins_p = 1'b0;
			st_next.del_p = 1'b0;
			if (st_reg.ctrl[`DAD_B_DEC_BYP]) begin
				smp_v = 1'b1;
			end else if (cntn >= 3'(`DAD_DEC_RATIO)) begin
				smp_v = 1'b1;
				smp = 16'(signed'(sum) >>> `DAD_DEC_SH);
				st_next.dec_acc = '0;
				st_next.dec_cnt = cntn - 3'(`DAD_DEC_RATIO);
			end else begin
				st_next.dec_acc = sum;
				st_next.dec_cnt = cntn;
			end
		end
		// Time equalizer FIR on the decimated stream.
		xn[0] = smp;
		for (int i = 1; i < NT; i++) begin
			xn[i] = st_reg.teq_x[i-1];
		end
		tacc = '0;
		for (int i = 0; i < NT; i++) begin
			tacc = tacc + 36'(signed'(st_reg.teq_c[i]) * signed'(xn[i]));
		end
		if (smp_v) begin
			st_next.rx_smp_v = 1'b1;
			if (st_reg.ctrl[`DAD_B_TEQ_BYP]) begin
				st_next.rx_smp = smp;
			end else begin
				st_next.teq_x = xn;
				st_next.rx_smp = tacc[`DAD_TEQ_Q+:16];
			end
			// Symbol framing for the receive transform.
			if (st_reg.rx_scnt == (st_reg.ctrl[`DAD_B_REMOTE] ?
				10'(`DAD_RX_SYM_RT - 1) : 10'(`DAD_RX_SYM_CO - 1))) begin
				st_next.rx_scnt = '0;
				st_next.rx_sym = 1'b1;
				sym_now = 1'b1;
			end else begin
				st_next.rx_scnt = st_reg.rx_scnt + 10'd1;
			end
		end
		// Active table takes the inactive one only on a symbol edge.
		if (sym_now & st_reg.feq_swap) begin
			st_next.feq_act = st_reg.feq_inact;
			st_next.feq_swap = 1'b0;
		end
		// Transmit chain: sidelobe IIR, clip, delay IIR, then hold for interpolation.
		c1 = 16'((signed'(tx_smp) >>> 1) + (signed'(st_reg.tx_s1) >>> 1));
		if (signed'(c1) > signed'(st_reg.clip)) begin
			c1 = st_reg.clip;
		end else if (signed'(c1) < -signed'(st_reg.clip)) begin
			c1 = 16'(-signed'(st_reg.clip));
		end
		s2n = 16'(signed'(c1) - (signed'(st_reg.tx_s2) >>> 2));
		if (tx_smp_v) begin
			st_next.tx_s1 = c1;
			st_next.tx_s2 = s2n;
			st_next.tx_hold = s2n;
			if (st_reg.tx_scnt == (st_reg.ctrl[`DAD_B_REMOTE] ?
				10'(`DAD_TX_SYM_RT - 1) : 10'(`DAD_TX_SYM_CO - 1))) begin
				st_next.tx_scnt = '0;
				st_next.tx_sym = 1'b1;
			end else begin
				st_next.tx_scnt = st_reg.tx_scnt + 10'd1;
			end
		end
		// Held word is resent every link word, giving four output words per input sample.
		st_next.tx_nib = afe_word_start ? st_reg.tx_hold[15:12] : st_reg.tx_sh[11:8];
		st_next.tx_sh = afe_word_start ? st_reg.tx_hold[11:0] : {st_reg.tx_sh[7:0], 4'h0};
		// Tracker: low-pass then integrate; large offsets become sample slips.
		lpn = 16'(signed'(st_reg.lp) + (17'(signed'(pe) - signed'(st_reg.lp)) >>> `DAD_LP_SH));
		estn = st_reg.est + 24'(signed'(lpn));
		if (pe_v) begin
			st_next.lp = lpn;
			st_next.est = estn;
			if (signed'(estn) > signed'(SLIP_THR)) begin
				st_next.est = estn - SLIP_THR;
				st_next.slip_del = 1'b1;
				st_next.del_p = 1'b1;
			end else if (signed'(estn) < -signed'(SLIP_THR)) begin
				st_next.est = estn + SLIP_THR;
				st_next.slip_ins = 1'b1;
				st_next.ins_p = 1'b1;
			end
		end
		// Demapper: float coefficient mantissa and exponent, slice, subset hint.
		pr = 32'(signed'(dm_re) * signed'(st_reg.feq_act[11:0])) <<< st_reg.feq_act[15:12];
		pi = 32'(signed'(dm_im) * signed'(st_reg.feq_act[11:0])) <<< st_reg.feq_act[15:12];
		mre = 32'(signed'(pr) >>> `DAD_FEQ_Q);
		mim = 32'(signed'(pi) >>> `DAD_FEQ_Q);
		if (dm_v_in) begin
			st_next.dm_v = 1'b1;
			st_next.dm_bits = {mre[15:9], mim[15:9]};
			if (st_reg.ctrl[`DAD_B_TCM_EN]) begin
				st_next.dm_bits[7] = dm_subset[1];
				st_next.dm_bits[0] = dm_subset[0];
			end
		end
		// Mapper: trellis bit, split into axes, odd-integer points, gain, rotor.
		mb = map_bits;
		if (st_reg.ctrl[`DAD_B_TCM_EN]) begin
			mb[0] = st_reg.tcm_st[0] ^ map_bits[1] ^ map_bits[0];
		end
		h = map_n >> 1;
		k = map_n - h;
		vim = mb & 14'((1 << h) - 1);
		vre = mb >> h;
		cre = 16'({vre, 1'b1}) - 16'(1 << k);
		cim = 16'({vim, 1'b1}) - 16'(1 << h);
		// Full-width products; a 16-bit product would lose the integer part before the shift.
		ftr = 16'(32'(signed'(cre) * signed'(st_reg.fine_tune_gain)) >>> `DAD_FTG_Q);
		fti = 16'(32'(signed'(cim) * signed'(st_reg.fine_tune_gain)) >>> `DAD_FTG_Q);
		if (map_v_in) begin
			st_next.map_err = map_n >= 4'(`DAD_MAX_N);
			st_next.map_v = map_n < 4'(`DAD_MAX_N);
			st_next.tcm_st = {st_reg.tcm_st[1:0], map_bits[1] ^ map_bits[0]};
			case (st_reg.est[`DAD_ROT_LSB+:2])
				2'd1: begin
					st_next.map_re = 16'(-signed'(fti));
					st_next.map_im = ftr;
				end
				2'd2: begin
					st_next.map_re = 16'(-signed'(ftr));
					st_next.map_im = 16'(-signed'(fti));
				end
				2'd3: begin
					st_next.map_re = fti;
					st_next.map_im = 16'(-signed'(ftr));
				end
				default: begin
					st_next.map_re = ftr;
					st_next.map_im = fti;
				end
			endcase
		end
		// Separate descrambler per flow, then flow selection.
		oi = dsc(st_reg.dsc_i, fi_data);
		of = dsc(st_reg.dsc_f, ff_data);
		if (fi_v) begin
			st_next.dsc_i = oi[30:8];
		end
		if (ff_v) begin
			st_next.dsc_f = of[30:8];
		end
		sel_v = st_reg.ctrl[`DAD_B_FLOW] ? ff_v : fi_v;
		sel_d = st_reg.ctrl[`DAD_B_FLOW] ? of[7:0] : oi[7:0];
		// Byte stream goes straight out with no FIFO, bypassing the cell layer.
		if (st_reg.port_en[2] & sel_v) begin
			st_next.sync_v = 1'b1;
			st_next.sync_data = sel_d;
		end
		// Internal cell FIFO; overflow is sticky because dropped bytes break cells.
		usel = st_reg.port_en[0] | st_reg.port_en[1];
		push = sel_v & usel & (st_reg.cnt != (AW+1)'(DEPTH));
		pop = (st_reg.cnt != '0) & (~st_reg.cell_v | cell_rdy);
		if (push) begin
			st_next.mem[st_reg.wp] = sel_d;
			st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
		end
		if (pop) begin
			st_next.cell_data = st_reg.mem[st_reg.rp];
			st_next.cell_v = 1'b1;
			st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
		end else if (cell_rdy) begin
			st_next.cell_v = 1'b0;
		end
		st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
		// Register writes; events below are applied after so a set beats a clear.
		if (wr_go) begin
			case (paddr)
				`DAD_A_CTRL: begin
					st_next.ctrl = pwdata[15:0];
					st_next.ctrl[`DAD_B_SWAP] = 1'b0;
					st_next.feq_swap = st_next.feq_swap | pwdata[`DAD_B_SWAP];
					case (dad_pkg::dad_port_e'(pwdata[`DAD_B_PORT+:2]))
						dad_pkg::DAD_PORT_U1: st_next.port_en = 3'b001;
						dad_pkg::DAD_PORT_U2: st_next.port_en = 3'b010;
						dad_pkg::DAD_PORT_SYNC: st_next.port_en = 3'b100;
						default: st_next.port_en = 3'b000;
					endcase
				end
				`DAD_A_STAT: st_next.ovf = st_reg.ovf & ~pwdata[`DAD_B_OVF];
				`DAD_A_EVT: begin
					st_next.rs_cnt = '0;
					st_next.crc_cnt = '0;
				end
				`DAD_A_FEQ: st_next.feq_inact = pwdata[15:0];
				`DAD_A_FTG: st_next.fine_tune_gain = pwdata[15:0];
				`DAD_A_CLIP: st_next.clip = pwdata[15:0];
				`DAD_A_SAMPLE_CLOCK_TRACKER: st_next.est = '0;
				default: begin
					for (int i = 0; i < NT; i++) begin
						if (paddr == 8'(`DAD_A_TEQ + 4 * i)) begin
							st_next.teq_c[i] = pwdata[15:0];
						end
					end
				end
			endcase
		end
		if (sel_v & usel & ~push) begin
			st_next.ovf = 1'b1;
		end
		if (rs_evt & (st_next.rs_cnt != 16'hFFFF)) begin
			st_next.rs_cnt = st_next.rs_cnt + 16'd1;
		end
		if (crc_evt & (st_next.crc_cnt != 16'hFFFF)) begin
			st_next.crc_cnt = st_next.crc_cnt + 16'd1;
		end
	end

	// State register; only constants under reset.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '0;
			st_reg.ctrl <= `DAD_RST_CTRL;
			st_reg.fine_tune_gain <= `DAD_RST_FTG;
			st_reg.clip <= `DAD_RST_CLIP;
			st_reg.feq_act <= `DAD_RST_FEQ;
			st_reg.feq_inact <= `DAD_RST_FEQ;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state record.
	assign prdata = st_reg.prdata;
	assign pready = st_reg.pready;
	assign pslverr = st_reg.pslverr;
	assign afe_tx_nib = st_reg.tx_nib;
	assign rx_smp = st_reg.rx_smp;
	assign rx_smp_v = st_reg.rx_smp_v;
	assign rx_sym = st_reg.rx_sym;
	assign tx_sym = st_reg.tx_sym;
	assign slip_ins = st_reg.slip_ins;
	assign slip_del = st_reg.slip_del;
	assign rot_q = st_reg.est[`DAD_ROT_LSB+:2];
	assign dm_bits = st_reg.dm_bits;
	assign dm_v = st_reg.dm_v;
	assign map_re = st_reg.map_re;
	assign map_im = st_reg.map_im;
	assign map_v = st_reg.map_v;
	assign map_err = st_reg.map_err;
	assign cell_data = st_reg.cell_data;
	assign cell_v = st_reg.cell_v;
	assign sync_data = st_reg.sync_data;
	assign sync_v = st_reg.sync_v;
	assign port_en = st_reg.port_en;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_tx_nibble: assert property (afe_word_start |=> afe_tx_nib == $past(st_reg.tx_hold[15:12]))
		else $error("Transmit nibble not the high nibble after word start.");
	a_both_bypass: assert property (word_done && st_reg.ctrl[`DAD_B_DEC_BYP] && st_reg.ctrl[`DAD_B_TEQ_BYP] |=>
		rx_smp_v && rx_smp == $past(word))
		else $error("Bypassed receive sample altered.");
	a_rx_symbol: assert property (rx_sym |-> rx_smp_v && st_reg.rx_scnt == 10'd0)
		else $error("Receive symbol edge off its count.");
	a_tx_symbol: assert property (tx_sym |-> $past(st_reg.tx_scnt) ==
		(st_reg.ctrl[`DAD_B_REMOTE] ? 10'(`DAD_TX_SYM_RT - 1) : 10'(`DAD_TX_SYM_CO - 1)))
		else $error("Transmit symbol length wrong.");
	a_feq_swap: assert property (sym_now && st_reg.feq_swap |=> st_reg.feq_act == $past(st_reg.feq_inact))
		else $error("Equalizer table not swapped on symbol edge.");
	a_map_range: assert property (map_v_in && map_n >= 4'(`DAD_MAX_N) |=> map_err && !map_v)
		else $error("Oversized constellation not refused.");
	a_rs_count: assert property (rs_evt && !wr_go && st_reg.rs_cnt < 16'hFFFF |=>
		st_reg.rs_cnt == $past(st_reg.rs_cnt) + 16'd1)
		else $error("Correction event not counted.");
	a_port_onehot: assert property ($onehot0(port_en) && (st_reg.cnt <= (AW+1)'(DEPTH)))
		else $error("More than one port enabled or FIFO overrun.");
	a_apb_wait: assert property (psel && penable && !pready |=> pready)
		else $error("APB access not completed after one wait state.");
endmodule // dad_datapath
`default_nettype wire

// file: src/dad_cfg.svh
// Register map, field positions, reset values and rate constants of the DMT data path.
`ifndef DAD_CFG_SVH
`define DAD_CFG_SVH
`define DAD_A_CTRL 8'h00
`define DAD_A_STAT 8'h04
`define DAD_A_EVT 8'h08
`define DAD_A_FEQ 8'h0C
`define DAD_A_FTG 8'h10
`define DAD_A_CLIP 8'h14
`define DAD_A_SAMPLE_CLOCK_TRACKER 8'h18
`define DAD_A_TEQ 8'h20
`define DAD_B_DEC_BYP 0
`define DAD_B_TEQ_BYP 1
`define DAD_B_REMOTE 2
`define DAD_B_TCM_EN 3
`define DAD_B_CELL 4
`define DAD_B_PORT 5
`define DAD_B_SWAP 8
`define DAD_B_FLOW 13
`define DAD_B_OVF 16
`define DAD_B_SWPEND 17
`define DAD_RST_CTRL 16'h0000
`define DAD_RST_FTG 16'h1000
`define DAD_RST_CLIP 16'h7FFF
`define DAD_RST_FEQ 16'h0400
`define DAD_FTG_Q 12
`define DAD_FEQ_Q 10
`define DAD_TEQ_Q 15
`define DAD_LP_SH 4
`define DAD_DEC_SH 2
`define DAD_DEC_RATIO 4
`define DAD_NIBS 4
`define DAD_RX_SYM_CO 128
`define DAD_RX_SYM_RT 1024
`define DAD_TX_SYM_CO 1024
`define DAD_TX_SYM_RT 512
`define DAD_FIFO_DEPTH 424
`define DAD_SLIP_THR 24'h10_0000
`define DAD_ROT_LSB 20
`define DAD_MAX_N 15
`endif

// file: src/dad_pkg.sv
// Shared types of the DMT data path.
package dad_pkg;
	// Selection of the single enabled user port.
	typedef enum logic [1:0] {
		DAD_PORT_OFF,
		DAD_PORT_U1,
		DAD_PORT_U2,
		DAD_PORT_SYNC
	} dad_port_e;
endpackage

// file: testbench/dad_afe_model.sv
// Analog front-end model: sends a repeating set of four receive words as nibbles.
`timescale 1ns/1ps
`default_nettype none
module dad_afe_model (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// Four words to send in turn, word 0 in the low bits.
	input wire logic [63:0] words,
	// Nibble link toward the data path.
	output logic [3:0] afe_rx_nib,
	output logic afe_word_start
);
	logic [1:0] nib_cnt;
	logic [1:0] word_idx;
	logic [15:0] cur;

	// The link never idles, so the word counters run from reset onward.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			nib_cnt <= 2'h0;
			word_idx <= 2'h0;
		end else begin
			nib_cnt <= nib_cnt + 2'h1;
			if (nib_cnt == 2'h3) begin
				word_idx <= word_idx + 2'h1;
			end
		end
	end

	// High nibble first; the start flag marks nibble zero of every word.
	always_comb begin
		cur = words[16*word_idx +: 16];
		afe_rx_nib = cur[4*(3-nib_cnt) +: 4];
		afe_word_start = rstn && (nib_cnt == 2'h0);
	end
endmodule // dad_afe_model
`default_nettype wire

// file: testbench/tb_dmt_adsl_datapath.sv
// Self-checking testbench of the DMT data path.
`timescale 1ns/1ps
`default_nettype none
`include "dad_cfg.svh"
module tb_dmt_adsl_datapath;
	logic clock, rstn, psel, penable, pwrite, pready, pslverr, er;
	logic tx_smp_v, pe_v, dm_v_in, map_v_in, fi_v, ff_v, rs_evt, crc_evt, cell_rdy;
	logic rx_smp_v, dm_v, map_v, map_err, cell_v, afe_word_start, rx_sym, tx_sym, slip_ins, slip_del, sync_v;
	logic [7:0] paddr, fi_data, ff_data, cell_data, sync_data;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] tx_smp, pe, dm_re, dm_im, rx_smp, last, map_re, map_im, w;
	logic [13:0] map_bits, dm_bits;
	logic [3:0] map_n, afe_rx_nib, afe_tx_nib;
	logic [1:0] dm_subset, rot_q;
	logic [2:0] port_en;
	logic [63:0] afe_words;
	int fail_count, n_tests, cnt;

	// The far end drives the receive nibbles.
	dad_afe_model u_afe (.clock(clock), .rstn(rstn), .words(afe_words), .afe_rx_nib(afe_rx_nib),
		.afe_word_start(afe_word_start));

	// Slip threshold shortened so tracking stays reachable in a short run.
	dad_datapath #(.SLIP_THR(24'h00_0100)) u_dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.afe_rx_nib(afe_rx_nib), .afe_word_start(afe_word_start), .afe_tx_nib(afe_tx_nib), .tx_smp(tx_smp),
		.tx_smp_v(tx_smp_v), .rx_smp(rx_smp), .rx_smp_v(rx_smp_v), .rx_sym(rx_sym), .tx_sym(tx_sym), .pe(pe),
		.pe_v(pe_v), .slip_ins(slip_ins), .slip_del(slip_del), .rot_q(rot_q), .dm_re(dm_re), .dm_im(dm_im),
		.dm_subset(dm_subset), .dm_v_in(dm_v_in), .dm_bits(dm_bits), .dm_v(dm_v), .map_bits(map_bits),
		.map_n(map_n), .map_v_in(map_v_in), .map_re(map_re), .map_im(map_im), .map_v(map_v), .map_err(map_err),
		.fi_data(fi_data), .fi_v(fi_v), .ff_data(ff_data), .ff_v(ff_v), .rs_evt(rs_evt), .crc_evt(crc_evt),
		.cell_data(cell_data), .cell_v(cell_v), .cell_rdy(cell_rdy), .sync_data(sync_data), .sync_v(sync_v),
		.port_en(port_en));

	// Free-running 100 MHz clock.
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// A wait that uses up its bound ends the run as a failure.
	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		tmo(n, 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, rd, exp);
	endtask

	// Let the path settle, then count output samples over 16 words.
	task automatic rx_run(input logic [15:0] exp, input int np);
		repeat (40) @(posedge clock);
		cnt = 0;
		repeat (64) begin
			@(posedge clock);
			if (rx_smp_v === 1'b1) begin
				cnt++;
				last = rx_smp;
			end
		end
		chk("rx_rate", 32'(cnt), 32'(np));
		chk("rx_value", {16'h0000, last}, {16'h0000, exp});
	endtask

	task automatic t_regs();
		rdchk("ctrl", `DAD_A_CTRL, 32'h0000_0000);
		rdchk("ftg", `DAD_A_FTG, 32'h0000_1000);
		rdchk("clip", `DAD_A_CLIP, 32'h0000_7FFF);
		rdchk("feq", `DAD_A_FEQ, 32'h0400_0400);
		apb(1'b1, `DAD_A_FEQ, 32'h0000_1234);
		rdchk("feq_inactive", `DAD_A_FEQ, 32'h0400_1234);
		apb(1'b0, 8'h1C, 32'h0000_0000);
		chk("unmapped", {31'h0, er}, 32'h0000_0001);
	endtask

	// Bypass and a half-gain equalizer tap on constant words, decimation on a four-word ramp.
	task automatic t_rx();
		apb(1'b1, `DAD_A_CTRL, 32'h0000_0003);
		afe_words <= 64'h1234_1234_1234_1234;
		rx_run(16'h1234, 16);
		apb(1'b1, `DAD_A_CTRL, 32'h0000_0002);
		afe_words <= 64'h0040_0030_0020_0010;
		rx_run(16'h0028, 4);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'(`DAD_A_TEQ + 4*i), (i == 0) ? 32'h0000_4000 : 32'h0000_0000);
		end
		apb(1'b1, `DAD_A_CTRL, 32'h0000_0001);
		afe_words <= 64'h1000_1000_1000_1000;
		rx_run(16'h0800, 16);
	endtask

	// Mapper refuses sizes of 15 bits; demapper answers one cycle later.
	task automatic t_map(input logic [3:0] n, input logic e);
		@(posedge clock);
		map_n <= n;
		dm_re <= 16'h1200;
		map_v_in <= 1'b1;
		dm_v_in <= 1'b1;
		@(posedge clock);
		map_v_in <= 1'b0;
		dm_v_in <= 1'b0;
		@(posedge clock);
		chk("map_err", {31'h0, map_err}, {31'h0, e});
		chk("map_v", {31'h0, map_v}, {31'h0, ~e});
		chk("dm_v", {31'h0, dm_v}, 32'h0000_0001);
		chk("dm_bits", {18'h0, dm_bits}, 32'h0000_0480);
		if (!e) begin
			// All-zero bits at unit gain give the most negative odd point on both axes.
			chk("map_point", {map_re, map_im}, 32'hFF81_FF81);
		end
	endtask

	task automatic t_evt();
		apb(1'b1, `DAD_A_EVT, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			rs_evt <= (i < 3);
			crc_evt <= (i < 2);
		end
		rdchk("evt", `DAD_A_EVT, 32'h0002_0003);
		apb(1'b1, `DAD_A_EVT, 32'h0000_0000);
		rdchk("evt_clr", `DAD_A_EVT, 32'h0000_0000);
	endtask

	task automatic t_port();
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, `DAD_A_CTRL, 32'(p << 5));
			@(posedge clock);
			chk("port_en", {29'h0, port_en}, (p == 0) ? 32'h0 : 32'(1 << (p - 1)));
		end
	endtask

	// Both flows offer a byte; the select bit decides which reaches the cell port.
	task automatic t_flow(input logic f);
		apb(1'b1, `DAD_A_CTRL, {18'h0, f, 13'h0033});
		@(posedge clock);
		{fi_data, ff_data, fi_v, ff_v} <= {8'hA5, 8'h5A, 2'b11};
		@(posedge clock);
		{fi_v, ff_v} <= 2'b00;
		cnt = 0;
		while (cell_v !== 1'b1 && cnt < 100) begin
			@(posedge clock);
			cnt++;
		end
		tmo(cnt, 100);
		chk("cell_data", {24'h0, cell_data}, f ? 32'h0000_005A : 32'h0000_00A5);
		cell_rdy <= 1'b1;
		@(posedge clock);
		cell_rdy <= 1'b0;
	endtask

	// The byte stream port takes the selected flow with no FIFO and no cell layer.
	task automatic t_sync();
		apb(1'b1, `DAD_A_CTRL, 32'h0000_0060);
		@(posedge clock);
		fi_data <= 8'h3C;
		fi_v <= 1'b1;
		@(posedge clock);
		fi_v <= 1'b0;
		@(posedge clock);
		// Third interleaved byte: only the first A5 byte reaches the x^18 and x^23 taps, as 8'h14.
		chk("sync", {23'h0, sync_v, sync_data}, 32'h0000_0128);
	endtask

	// A clipped first sample goes out high nibble first; symbols are counted per sample.
	task automatic t_tx();
		int k;
		apb(1'b1, `DAD_A_CLIP, 32'h0000_0100);
		@(posedge clock);
		tx_smp <= 16'h7000;
		tx_smp_v <= 1'b1;
		@(posedge clock);
		tx_smp_v <= 1'b0;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (afe_word_start !== 1'b1 && k < 8);
		tmo(k, 8);
		repeat (4) begin
			@(posedge clock);
			w = {w[11:0], afe_tx_nib};
		end
		chk("tx_word", {16'h0000, w}, 32'h0000_0100);
		tx_smp_v <= 1'b1;
		k = 0;
		while (tx_sym !== 1'b1 && k < 1100) begin
			@(posedge clock);
			k++;
		end
		tmo(k, 1100);
		cnt = 0;
		do begin
			@(posedge clock);
			cnt++;
		end while (tx_sym !== 1'b1 && cnt < 1100);
		tmo(cnt, 1100);
		tx_smp_v <= 1'b0;
		chk("tx_symbol", 32'(cnt), 32'(`DAD_TX_SYM_CO));
	endtask

	// Receive symbol length in both unit roles, counted in bypassed samples.
	task automatic t_sym(input logic rm);
		int k;
		apb(1'b1, `DAD_A_CTRL, {29'h0, rm, 2'b11});
		k = 0;
		while (rx_sym !== 1'b1 && k < 5000) begin
			@(posedge clock);
			k++;
		end
		tmo(k, 5000);
		cnt = 0;
		k = 0;
		do begin
			@(posedge clock);
			k++;
			cnt += int'(rx_smp_v === 1'b1);
		end while (rx_sym !== 1'b1 && k < 5000);
		tmo(k, 5000);
		chk("rx_symbol", 32'(cnt), rm ? 32'(`DAD_RX_SYM_RT) : 32'(`DAD_RX_SYM_CO));
	endtask

	// A large pilot error forces a slip; a negative one turns the rotor back one quadrant.
	task automatic t_sample_clock_tracker();
		@(posedge clock);
		pe <= 16'h7FF0;
		pe_v <= 1'b1;
		@(posedge clock);
		pe_v <= 1'b0;
		@(posedge clock);
		chk("slip", {30'h0, slip_ins, slip_del}, 32'h0000_0001);
		rdchk("estimate", `DAD_A_SAMPLE_CLOCK_TRACKER, 32'h0000_06FF);
		apb(1'b1, `DAD_A_SAMPLE_CLOCK_TRACKER, 32'h0000_0000);
		pe <= 16'h8000;
		pe_v <= 1'b1;
		@(posedge clock);
		pe_v <= 1'b0;
		@(posedge clock);
		chk("rotor", {28'h0, rot_q, slip_ins, slip_del}, 32'h0000_000C);
	endtask

	// Reset, then every scenario in turn.
	initial begin
		{rstn, psel, penable, pwrite, tx_smp_v, pe_v, dm_v_in, map_v_in} = 8'h00;
		{fi_v, ff_v, rs_evt, crc_evt, cell_rdy} = 5'h00;
		{paddr, fi_data, ff_data, pwdata} = 56'h0;
		{tx_smp, pe, dm_re, dm_im, map_bits, map_n, dm_subset} = 84'h0;
		afe_words = 64'h0000_0000_0000_0000;
		fail_count = 0;
		n_tests = 0;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		t_regs();
		t_rx();
		t_map(4'hE, 1'b0);
		t_map(4'hF, 1'b1);
		t_evt();
		t_port();
		t_flow(1'b0);
		t_flow(1'b1);
		t_sync();
		t_tx();
		t_sym(1'b0);
		t_sym(1'b1);
		t_sample_clock_tracker();
		report_and_stop();
	end
endmodule // tb_dmt_adsl_datapath
`default_nettype wire
